// file: design/ditp_curve.sv
// Purpose: filter one input sample and map it through a two-point curve
// Assumes: step_i pulses once every 10 ms
// Notes: setting is registered, one cycle behind the filter
`timescale 1ns/1ps
module ditp_curve (
   input wire logic clock_i, // system clock
   input wire logic reset_i, // sync reset, active high
   input wire logic step_i, // filter step strobe
   input wire logic signed [15:0] sample_i, // scaled input sample
   input wire ditp_pkg::ditp_curve_t curve_i, // curve points
   input wire logic below_zero_i, // force 0 % below minimum
   input wire logic [9:0] filter_tc_i, // time constant, 10 ms units
   output logic signed [15:0] setting_o // curve output, 0.1 % units
);
   import ditp_pkg::*;
   logic signed [15:0] filt_reg, filt_next;
   logic signed [15:0] set_reg, set_next;
   logic signed [31:0] diff, den, quo, span_in, span_set, interp;

   // ==========================================================
   // first-order filter; quotient floored to one lsb so it settles
   always_comb begin
      diff = 32'(filt_reg);
      diff = 32'(sample_i) - diff;
      den = $signed({22'h00_0000, filter_tc_i}) + 32'sh0000_0001;
      quo = diff / den;
      if (quo == 0 && diff > 0) begin
         quo = 32'sh0000_0001;
      end else if (quo == 0 && diff < 0) begin
         quo = -32'sh0000_0001;
      end
      filt_next = filt_reg;
      if (step_i) begin
         filt_next = filt_reg + quo[15:0];
      end
   end

   // ==========================================================
   // curve evaluation
   always_comb begin
      span_in = 32'(curve_i.max_in) - 32'(curve_i.min_in);
      span_set = 32'(curve_i.max_set) - 32'(curve_i.min_set);
      interp = 32'(curve_i.max_set);
      if (span_in != 0) begin
         interp = (32'(filt_reg) - 32'(curve_i.min_in)) * span_set / span_in;
         interp = interp + 32'(curve_i.min_set);
      end
      if (filt_reg > curve_i.max_in) begin
         interp = 32'(curve_i.max_set);
      end else if (filt_reg < curve_i.min_in) begin
         interp = below_zero_i ? 32'sh0000_0000 : 32'(curve_i.min_set);
      end
      // points outside the legal span are held to +-100.0 %
      if (interp > 32'(SET_FULL)) begin
         set_next = SET_FULL;
      end else if (interp < -32'(SET_FULL)) begin
         set_next = -SET_FULL;
      end else begin
         set_next = interp[15:0];
      end
   end

   // state registers
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         filt_reg <= 16'sh0000;
         set_reg <= 16'sh0000;
      end else begin
         filt_reg <= filt_next;
         set_reg <= set_next;
      end
   end

   assign setting_o = set_reg;
endmodule : ditp_curve

// file: design/ditp_pkg.sv
// Purpose: shared constants and types for drive input terminal processing
// Assumes: 10 MHz clock, settings held stable by the configuring side
// Notes: analog units 0.01 V, settings 0.1 %, pulse units 10 Hz
package ditp_pkg;
   // ==========================================================
   // terminal layout and function codes
   localparam int NUM_DI = 5;
   localparam int NUM_DELAYED = 3;
   localparam int PULSE_DI = 4; // fifth input carries pulse train
   localparam logic [4:0] FN_FWD = 5'h01;
   localparam logic [4:0] FN_REV = 5'h02;
   localparam logic [4:0] FN_3WIRE = 5'h03;
   localparam logic [4:0] FN_UP = 5'h06;
   localparam logic [4:0] FN_DOWN = 5'h07;
   // ==========================================================
   // timing
   localparam int CLK_NS = 100;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
   localparam int FILT_STEP_MS = 10; // filter time lsb is 0.01 s
   localparam int DELAY_MS_PER_LSB = 100; // delay lsb is 0.1 s
   localparam int GATE_MS = 100; // 100 ms gate gives 10 Hz per count
   // ==========================================================
   // scaling and limits
   localparam logic signed [31:0] FINE_PER_LSB = 32'sh0000_2710; // 10 rate lsb * 1000 ms
   localparam logic signed [15:0] AIN_FULL = 16'sh03e8; // 10.00 V
   localparam logic signed [15:0] SET_FULL = 16'sh03e8; // 100.0 %
   localparam logic signed [15:0] PULSE_MAX = 16'sh2710; // 100.00 kHz
   localparam logic [15:0] RATE_MIN = 16'h0001;
   // ==========================================================
   // values after reset and factory defaults
   localparam logic [2:0] RESET_STATE = 3'h1;
   localparam logic [9:0] DEF_DEBOUNCE_MS = 10'h00a; // 0.010 s
   localparam logic [9:0] DEF_FILT_TC = 10'h00a; // 0.10 s
   localparam logic [7:0] DEF_CURVE_SEL = 8'h21; // 321, two inputs used
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      METH_2W1 = 2'h0,
      METH_2W2 = 2'h1,
      METH_3W1 = 2'h2,
      METH_3W2 = 2'h3
   } ditp_method_t;
   typedef enum logic [2:0] {
      ST_STOP = 3'h1,
      ST_FWD = 3'h2,
      ST_REV = 3'h4
   } ditp_state_t;
   typedef struct packed {
      logic signed [15:0] min_in;
      logic signed [15:0] min_set;
      logic signed [15:0] max_in;
      logic signed [15:0] max_set;
   } ditp_curve_t;
   typedef struct packed {
      logic run;
      logic reverse;
   } ditp_run_t;
   typedef logic [NUM_DI-1:0][4:0] ditp_func_t;
endpackage : ditp_pkg

// file: design/ditp_top.sv
// Purpose: decode run terminals, slew up/down frequency, scale inputs
// Assumes: contact pins asynchronous, samples from same-clock converters
// Notes: one millisecond tick drives every slow timer
//
// Overview of operation
// - method 0, one input alone sets direction
// - method 1, forward enables, reverse picks direction
// - method 2, pulses start, enable opening stops
// - method 3, forward pulse runs, reverse level directs
// - up/down slews frequency at rate per second
// - decimal setting unused, rate resolution fixed
// - curves map two points within 100 percent
// - input above maximum treated as maximum
// - current input scaled half volt per milliamp
// - each analog input gets settable filter
// - third curve accepts inputs down to minus ten
// - pulse input only on fifth terminal, capped
// - curve select digits pick curve per input
// - below minimum gives minimum setting or zero
// - inputs one to three get change delay
// - active level choice flips contact meaning
// - method setting selects four control methods
// - functions one and two are run inputs
// - all terminal states pass settable debounce filter, pulse capture does not
`timescale 1ns/1ps
module ditp_top #(
   parameter int MS_TICK_CYCLES = ditp_pkg::MS_CYCLES // cycles per 1 ms
) (
   input wire logic clock_i, // system clock
   input wire logic reset_i, // sync reset, active high
   input wire logic [4:0] contact_i, // 1 = closed to common_return
   input wire logic [4:0] input_active_level_setting_i, // 1 = active low
   input wire logic [9:0] debounce_ms_i, // debounce, 1 ms units
   input wire logic [2:0][15:0] delay_setting_i, // delay, 0.1 s units
   input wire ditp_pkg::ditp_func_t terminal_function_i, // per input
   input wire logic [1:0] command_method_setting_i, // 0..3
   input wire logic [15:0] updown_rate_setting_i, // rate per second
   input wire logic [1:0] frequency_decimal_setting_i, // 1 or 2
   input wire logic [15:0] freq_base_i, // digital set frequency
   input wire logic [15:0] freq_max_i, // frequency ceiling
   input wire logic [1:0][15:0] ai_sample_i, // 0.01 V or 0.01 mA
   input wire logic [1:0] ai_current_i, // 1 = current mode
   input wire ditp_pkg::ditp_curve_t [2:0] curve_i, // analog curves
   input wire ditp_pkg::ditp_curve_t pulse_curve_i, // pulse curve
   input wire logic [7:0] curve_select_setting_i, // tens, ones digit
   input wire logic [7:0] below_min_select_setting_i, // tens, ones
   input wire logic [1:0][9:0] ai_filter_i, // 10 ms units
   input wire logic [9:0] pulse_filter_i, // 10 ms units
   output ditp_pkg::ditp_run_t run_cmd_o, // run and direction
   output logic [4:0] terminal_state_o, // valid terminal levels
   output logic [15:0] set_freq_o, // adjusted set frequency
   output logic [1:0][15:0] ai_setting_o, // 0.1 % units, signed
   output logic [15:0] pulse_freq_o, // measured, 10 Hz units
   output logic [15:0] pulse_setting_o // 0.1 % units, signed
);
   import ditp_pkg::*;

   // ==========================================================
   // function decode, shared by every command input
   function automatic logic any_func(input ditp_func_t fn, input logic [4:0] st,
                                     input logic [4:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_DI; i++) begin
         if (fn[i] == code && st[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : any_func

   // curve choice from one select digit; out-of-range falls to curve 1
   function automatic ditp_curve_t pick_curve(input logic [3:0] digit,
                                              input ditp_curve_t [2:0] c);
      ditp_curve_t sel;
      sel = c[0];
      if (digit == 4'h2) begin
         sel = c[1];
      end else if (digit == 4'h3) begin
         sel = c[2];
      end
      return sel;
   endfunction : pick_curve

   // ==========================================================
   // input synchronisers; second stage is the only reader of the first
   logic [4:0] sync1_reg, sync2_reg;
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
      end else begin
         sync1_reg <= contact_i;
         sync2_reg <= sync1_reg;
      end
   end

   // ==========================================================
   // millisecond, 10 ms and gate ticks
   logic [23:0] ms_cnt_reg, ms_cnt_next;
   logic [3:0] step_cnt_reg, step_cnt_next;
   logic [6:0] gate_cnt_reg, gate_cnt_next;
   logic tick_ms, tick_step, tick_gate;

   always_comb begin
      tick_ms = (ms_cnt_reg == 24'(MS_TICK_CYCLES - 1));
      tick_step = tick_ms && (step_cnt_reg == 4'(FILT_STEP_MS - 1));
      tick_gate = tick_ms && (gate_cnt_reg == 7'(GATE_MS - 1));
      ms_cnt_next = tick_ms ? 24'h00_0000 : ms_cnt_reg + 24'h00_0001;
      step_cnt_next = step_cnt_reg;
      gate_cnt_next = gate_cnt_reg;
      if (tick_ms) begin
         step_cnt_next = tick_step ? 4'h0 : step_cnt_reg + 4'h1;
         gate_cnt_next = tick_gate ? 7'h00 : gate_cnt_reg + 7'h01;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ms_cnt_reg <= 24'h00_0000;
         step_cnt_reg <= 4'h0;
         gate_cnt_reg <= 7'h00;
      end else begin
         ms_cnt_reg <= ms_cnt_next;
         step_cnt_reg <= step_cnt_next;
         gate_cnt_reg <= gate_cnt_next;
      end
   end

   // ==========================================================
   // per-terminal level choice, debounce and change delay
   logic [4:0] term_valid;
   genvar k;
   generate
      for (k = 0; k < NUM_DI; k++) begin : g_term
         logic level;
         logic deb_reg, deb_next, state_reg, state_next;
         logic [9:0] deb_cnt_reg, deb_cnt_next;
         logic [21:0] dly_cnt_reg, dly_cnt_next, dly_target;

         // only the first three terminals have a change delay
         if (k < NUM_DELAYED) begin : g_dly
            assign dly_target = 22'(delay_setting_i[k]) * 22'(DELAY_MS_PER_LSB);
         end else begin : g_nodly
            assign dly_target = 22'h00_0000;
         end

         // closed contact is valid unless active low is chosen
         assign level = sync2_reg[k] ^ input_active_level_setting_i[k];

         always_comb begin
            deb_next = deb_reg;
            deb_cnt_next = deb_cnt_reg;
            if (level == deb_reg) begin
               deb_cnt_next = 10'h000;
            end else if (deb_cnt_reg >= debounce_ms_i) begin
               deb_next = level;
               deb_cnt_next = 10'h000;
            end else if (tick_ms) begin
               deb_cnt_next = deb_cnt_reg + 10'h001;
            end
            state_next = state_reg;
            dly_cnt_next = dly_cnt_reg;
            if (deb_reg == state_reg) begin
               dly_cnt_next = 22'h00_0000;
            end else if (dly_cnt_reg >= dly_target) begin
               state_next = deb_reg;
               dly_cnt_next = 22'h00_0000;
            end else if (tick_ms) begin
               dly_cnt_next = dly_cnt_reg + 22'h00_0001;
            end
         end

         always_ff @(posedge clock_i) begin
            if (reset_i) begin
               deb_reg <= 1'b0;
               state_reg <= 1'b0;
               deb_cnt_reg <= 10'h000;
               dly_cnt_reg <= 22'h00_0000;
            end else begin
               deb_reg <= deb_next;
               state_reg <= state_next;
               deb_cnt_reg <= deb_cnt_next;
               dly_cnt_reg <= dly_cnt_next;
            end
         end

         assign term_valid[k] = state_reg;
      end
   endgenerate

   // ==========================================================
   // run command state machine
   logic forward_run_input, reverse_run_input, enable_input;
   logic fwd_prev_reg, rev_prev_reg, fwd_rise, rev_rise;
   ditp_state_t state_reg, state_next;
   ditp_method_t method;

   always_comb begin
      forward_run_input = any_func(terminal_function_i, term_valid, FN_FWD);
      reverse_run_input = any_func(terminal_function_i, term_valid, FN_REV);
      // enable exists only where some input carries the three-wire function
      enable_input = any_func(terminal_function_i, term_valid, FN_3WIRE);
      fwd_rise = forward_run_input && !fwd_prev_reg;
      rev_rise = reverse_run_input && !rev_prev_reg;
      method = ditp_method_t'(command_method_setting_i);
      state_next = state_reg;
      case (method)
         METH_2W1: begin
            if (forward_run_input && !reverse_run_input) begin
               state_next = ST_FWD;
            end else if (reverse_run_input && !forward_run_input) begin
               state_next = ST_REV;
            end else begin
               state_next = ST_STOP;
            end
         end
         METH_2W2: begin
            if (!forward_run_input) begin
               state_next = ST_STOP;
            end else begin
               state_next = reverse_run_input ? ST_REV : ST_FWD;
            end
         end
         METH_3W1: begin
            // forward wins when both buttons rise in one cycle
            if (!enable_input) begin
               state_next = ST_STOP;
            end else if (fwd_rise) begin
               state_next = ST_FWD;
            end else if (rev_rise) begin
               state_next = ST_REV;
            end
         end
         METH_3W2: begin
            if (!enable_input) begin
               state_next = ST_STOP;
            end else if (state_reg != ST_STOP || fwd_rise) begin
               state_next = reverse_run_input ? ST_REV : ST_FWD;
            end
         end
         default: begin
            state_next = ST_STOP;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_reg <= ST_STOP;
         fwd_prev_reg <= 1'b0;
         rev_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         fwd_prev_reg <= forward_run_input;
         rev_prev_reg <= reverse_run_input;
      end
   end

   // ==========================================================
   // up/down frequency slew
   logic up_input, down_input;
   logic [15:0] rate_eff;
   logic signed [31:0] ofs_reg, ofs_next, ofs_lo, ofs_hi, freq_sum;
   logic [15:0] freq_reg, freq_next;

   // offset kept in thousandths of the rate lsb per ms, so slow rates
   // still move; frequency lsb is ten rate lsb at either decimal setting
   always_comb begin
      up_input = any_func(terminal_function_i, term_valid, FN_UP);
      down_input = any_func(terminal_function_i, term_valid, FN_DOWN);
      rate_eff = updown_rate_setting_i;
      if (rate_eff < RATE_MIN) begin
         rate_eff = RATE_MIN;
      end
      ofs_lo = -($signed({16'h0000, freq_base_i}) * FINE_PER_LSB);
      ofs_hi = ($signed({16'h0000, freq_max_i}) - $signed({16'h0000, freq_base_i}));
      ofs_hi = ofs_hi * FINE_PER_LSB;
      ofs_next = ofs_reg;
      if (tick_ms && up_input && !down_input) begin
         ofs_next = ofs_reg + $signed({16'h0000, rate_eff});
      end else if (tick_ms && down_input && !up_input) begin
         ofs_next = ofs_reg - $signed({16'h0000, rate_eff});
      end
      if (ofs_next > ofs_hi) begin
         ofs_next = ofs_hi;
      end
      if (ofs_next < ofs_lo) begin
         ofs_next = ofs_lo;
      end
      freq_sum = $signed({16'h0000, freq_base_i}) + ofs_reg / FINE_PER_LSB;
      freq_next = (freq_sum < 0) ? 16'h0000 : freq_sum[15:0];
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ofs_reg <= 32'sh0000_0000;
         freq_reg <= 16'h0000;
      end else begin
         ofs_reg <= ofs_next;
         freq_reg <= freq_next;
      end
   end

   // ==========================================================
   // pulse frequency capture on the fifth terminal
   logic pulse_capture_input, pulse_prev_reg;
   logic [15:0] edge_cnt_reg, edge_cnt_next, pfreq_reg, pfreq_next;
   ditp_curve_t pulse_curve;

   always_comb begin
      pulse_capture_input = sync2_reg[PULSE_DI];
      edge_cnt_next = edge_cnt_reg;
      if (pulse_capture_input && !pulse_prev_reg && edge_cnt_reg != 16'hffff) begin
         edge_cnt_next = edge_cnt_reg + 16'h0001;
      end
      pfreq_next = pfreq_reg;
      if (tick_gate) begin
         pfreq_next = edge_cnt_next;
         edge_cnt_next = 16'h0000;
      end
      // curve maximum may not pass 100.00 kHz
      pulse_curve = pulse_curve_i;
      if (pulse_curve.max_in > PULSE_MAX) begin
         pulse_curve.max_in = PULSE_MAX;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pulse_prev_reg <= 1'b0;
         edge_cnt_reg <= 16'h0000;
         pfreq_reg <= 16'h0000;
      end else begin
         pulse_prev_reg <= pulse_capture_input;
         edge_cnt_reg <= edge_cnt_next;
         pfreq_reg <= pfreq_next;
      end
   end

   // saturate so a wild pulse train cannot wrap negative in the curve
   logic signed [15:0] pulse_sample;
   assign pulse_sample = (pfreq_reg > 16'(PULSE_MAX)) ? PULSE_MAX : pfreq_reg;

   ditp_curve u_pulse_curve (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .step_i(tick_step),
      .sample_i(pulse_sample),
      .curve_i(pulse_curve),
      .below_zero_i(1'b0),
      .filter_tc_i(pulse_filter_i),
      .setting_o(pulse_setting_o)
   );

   // ==========================================================
   // analog inputs: scale, limit, pick curve, filter and map
   generate
      for (k = 0; k < 2; k++) begin : g_ai
         logic signed [15:0] raw, volts, sample;
         ditp_curve_t curve;
         logic [3:0] digit;

         always_comb begin
            raw = ai_sample_i[k];
            volts = ai_current_i[k] ? (raw >>> 1) : raw;
            // bipolar range kept; only curve 3 points reach below zero
            sample = volts;
            if (volts > AIN_FULL) begin
               sample = AIN_FULL;
            end else if (volts < -AIN_FULL) begin
               sample = -AIN_FULL;
            end
            digit = curve_select_setting_i[4*k +: 4];
            curve = pick_curve(digit, curve_i);
         end

         ditp_curve u_ai_curve (
            .clock_i(clock_i),
            .reset_i(reset_i),
            .step_i(tick_step),
            .sample_i(sample),
            .curve_i(curve),
            .below_zero_i(below_min_select_setting_i[4*k]),
            .filter_tc_i(ai_filter_i[k]),
            .setting_o(ai_setting_o[k])
         );
      end
   endgenerate

   // ==========================================================
   // outputs
   assign run_cmd_o.run = (state_reg != ST_STOP);
   assign run_cmd_o.reverse = (state_reg == ST_REV);
   assign terminal_state_o = term_valid;
   assign set_freq_o = freq_reg;
   assign pulse_freq_o = pfreq_reg;
endmodule : ditp_top

// file: verification/ditp_checker.sv
// Purpose: run decode, terminal level and setting range checks
// Assumes: inputs 0..4 carry forward, reverse, enable, up, down
// Notes: decode checks stay idle under any other layout
`timescale 1ns/1ps
module ditp_checker
   import ditp_pkg::*;
(
   input wire logic clock_i, // clock
   input wire logic reset_i, // reset
   input wire logic [4:0] contact_i, // raw contacts
   input wire logic [4:0] input_active_level_setting_i, // levels
   input wire logic [9:0] debounce_ms_i, // debounce
   input wire ditp_pkg::ditp_func_t terminal_function_i, // functions
   input wire logic [1:0] command_method_setting_i, // method
   input wire ditp_pkg::ditp_run_t run_cmd_o, // run out
   input wire logic [4:0] terminal_state_o, // valid levels
   input wire logic [1:0][15:0] ai_setting_o // settings
);
   // ==========================================================
   // layout decode
   logic cfg, f, r, e;
   logic [1:0] m;
   assign cfg = terminal_function_i == {FN_DOWN, FN_UP, FN_3WIRE, FN_REV, FN_FWD};
   assign f = terminal_state_o[0];
   assign r = terminal_state_o[1];
   assign e = terminal_state_o[2];
   assign m = command_method_setting_i;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   property p_m0;
      cfg && m == 2'h0 |=> run_cmd_o == {$past(f ^ r), $past(r & !f)};
   endproperty
   a_m0: assert property (p_m0) else $error("two-wire one decode");
   property p_m1;
      cfg && m == 2'h1 |=> run_cmd_o == {$past(f), $past(f & r)};
   endproperty
   a_m1: assert property (p_m1) else $error("two-wire two decode");
   property p_off;
      cfg && m[1] && !e |=> !run_cmd_o.run;
   endproperty
   a_off: assert property (p_off) else $error("enable open kept run");
   property p_go;
      cfg && m == 2'h2 && e && f && !$past(f) && !r |=> run_cmd_o == 2'b10;
   endproperty
   a_go: assert property (p_go) else $error("forward pulse ignored");
   property p_dir;
      cfg && m == 2'h3 && e && run_cmd_o.run |=> run_cmd_o == {1'b1, $past(r)};
   endproperty
   a_dir: assert property (p_dir) else $error("direction not level");
   property p_lvl;
      (debounce_ms_i == 10'h000 && $stable(input_active_level_setting_i)) [*5] |->
         terminal_state_o[4:3] ==
         $past(contact_i[4:3] ^ input_active_level_setting_i[4:3], 4);
   endproperty
   a_lvl: assert property (p_lvl) else $error("terminal level wrong");
   property p_rng;
      $signed(ai_setting_o[0]) <= 1000 && $signed(ai_setting_o[0]) >= -1000;
   endproperty
   a_rng: assert property (p_rng) else $error("setting out of range");
   property p_stp;
      run_cmd_o.reverse |-> run_cmd_o.run;
   endproperty
   a_stp: assert property (p_stp) else $error("reverse while stopped");
endmodule : ditp_checker
bind ditp_top ditp_checker u_chk (.*);

// file: verification/ditp_switches.sv
// Purpose: operator switches and buttons on the contact pins
// Assumes: press_i is what the operator holds down
// Notes: contacts move only after a clock edge
`timescale 1ns/1ps
module ditp_switches (
   input wire logic clock_i, // bench clock
   input wire logic [4:0] press_i, // 1 = button held
   output logic [4:0] contact_o // 1 = closed to common_return
);
   // ==========================================================
   // contact state
   logic [4:0] held = 5'h00; // open at power-up, never unknown
   assign contact_o = held;
   // follow the hand one edge late
   always @(posedge clock_i) begin
      held <= press_i;
   end
endmodule : ditp_switches

// file: verification/ditp_top_test.sv
// Purpose: directed tests of run decode, up/down, curves, levels
// Assumes: one millisecond shortened to 10 clock cycles
// Notes: settle waits are generous, not measured latencies
`timescale 1ns/1ps
module ditp_top_test;
   import ditp_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic [4:0] sw = 5'h00, contact_i, input_active_level_setting_i = 5'h00;
   logic [9:0] debounce_ms_i = 10'h000, pulse_filter_i = 10'h000;
   logic [2:0][15:0] delay_setting_i = 48'h0000_0000_0000;
   ditp_func_t terminal_function_i = {FN_DOWN, FN_UP, FN_3WIRE, FN_REV, FN_FWD};
   logic [1:0] command_method_setting_i = 2'h0, frequency_decimal_setting_i = 2'h2;
   logic [15:0] updown_rate_setting_i = 16'hffff, freq_base_i = 16'h0064;
   logic [15:0] freq_max_i = 16'h0096, set_freq_o, pulse_freq_o, pulse_setting_o;
   logic [1:0][15:0] ai_sample_i = 32'h0000_0000, ai_setting_o;
   logic [1:0] ai_current_i = 2'h2;
   ditp_curve_t [2:0] curve_i = {64'hfc18_fc18_03e8_03e8,
      64'h0000_0000_03e8_03e8, 64'h0064_00c8_03e8_03e8};
   ditp_curve_t pulse_curve_i = 64'h0000_0000_1388_03e8;
   logic [7:0] curve_select_setting_i = 8'h21, below_min_select_setting_i = 8'h00;
   logic [1:0][9:0] ai_filter_i = 20'h0_0000;
   ditp_run_t run_cmd_o;
   logic [4:0] terminal_state_o;
   int num_errors = 0, checks_done = 0;
   always #50 clock_i = ~clock_i;
   // ==========================================================
   // far side and design
   ditp_switches u_sw (.clock_i, .press_i(sw), .contact_o(contact_i));
   ditp_top #(.MS_TICK_CYCLES(10)) u_dut (.*);
   // ==========================================================
   // helper tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
   endtask : step
   // call only right after a clock edge
   task automatic press(input logic [4:0] v, input int n);
      sw <= v;
      step(n);
   endtask : press
   task automatic crun(input logic [1:0] e);
      chk({14'h0000, run_cmd_o}, {14'h0000, e});
   endtask : crun
   // filter steps every 10 ms, so give it several steps
   task automatic aichk(input logic [15:0] a, input logic [15:0] e);
      ai_sample_i[0] <= a;
      step(300);
      chk(ai_setting_o[0], e);
   endtask : aichk
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // ==========================================================
   // main sequence
   initial begin
      step(2);
      reset_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         command_method_setting_i <= i[2] ? 2'h1 : 2'h0;
         press({3'h0, i[1:0]}, 12);
         crun(2'(16'hc838 >> (2 * i)));
      end
      $display("test two_wire done");
      command_method_setting_i <= 2'h2;
      press(5'h04, 8);
      press(5'h05, 8);
      press(5'h04, 8);
      crun(2'h2);
      press(5'h06, 8);
      press(5'h04, 8);
      crun(2'h3);
      press(5'h00, 8);
      crun(2'h0);
      command_method_setting_i <= 2'h3;
      press(5'h06, 8);
      press(5'h07, 8);
      press(5'h06, 8);
      crun(2'h3);
      press(5'h04, 8);
      crun(2'h2);
      press(5'h00, 8);
      crun(2'h0);
      $display("test three_wire done");
      // up then down, far enough to reach both clamps
      command_method_setting_i <= 2'h0;
      press(5'h08, 600);
      chk(set_freq_o, 16'h0096);
      press(5'h10, 1500);
      chk(set_freq_o, 16'h0000);
      press(5'h00, 4);
      $display("test updown done");
      ai_sample_i[1] <= 16'h03e8;
      aichk(16'h07d0, 16'h03e8);
      chk(ai_setting_o[1], 16'h01f4);
      aichk(16'h0226, 16'h0258);
      aichk(16'h0032, 16'h00c8);
      below_min_select_setting_i <= 8'h01;
      aichk(16'h0032, 16'h0000);
      curve_select_setting_i <= 8'h03;
      aichk(16'hfda8, 16'hfda8);
      $display("test analog done");
      // delayed input one, then active-low on input five
      delay_setting_i[0] <= 16'h0001;
      press(5'h01, 500);
      chk({11'h000, terminal_state_o}, 16'h0000);
      step(1000);
      chk({11'h000, terminal_state_o}, 16'h0001);
      input_active_level_setting_i <= 5'h10;
      press(5'h08, 12);
      chk({11'h000, terminal_state_o}, 16'h0019);
      $display("test levels done");
      // one edge per 4 cycles gives 250 edges per 1000-cycle gate
      repeat (2000) press(sw ^ 5'h10, 2);
      chk(pulse_freq_o, 16'h00fa);
      chk(pulse_setting_o, 16'h0032);
      $display("test pulse done");
      print_verdict;
   end
   // hang guard, about twice the 9302 cycles used
   initial begin
      step(20000);
      num_errors++;
      print_verdict;
   end
endmodule : ditp_top_test
